// *** ccr_register_bank.sv ***
// Operation
// - writing 1 to kick bit restarts watchdog; bit self-clears and reads 0.
// - mode bit selects charger at 0, boost at 1; resets to 0.
// - charge status reads 00 ready, 01 charging, 10 done, 11 fault.
// - fault field 000 none, 001 overvoltage, higher codes for other faults.
// - each status change or fault gives one 128 us interrupt pulse, and a status pulse if status enable set or fault; events during a pulse are dropped.
// - fault field holds until read and condition gone.
// - several faults show only highest priority, code 1 highest.
// - charge status tracks present condition, returns after fault removal.
// - ship bit latches device off until undervoltage lockout falls; host may clear.
// - reset bit restores defaults, enters default mode, stops watchdog; reads 1.
// - three-bit input limit code selects 100 to 2500 mA as listed.
// - in default mode the select pin decides the input current limit.
// - status enable set reports charge activity; cleared reports faults only.
// - termination enable allows current termination; cleared suppresses it.
// - active-low charge enable; disabled regulates system rail, battery disconnected unless supplement input set.
// - high impedance turns converter off, battery switch on, gate output low.
// - battery target 3.5 V plus code times 20 mV, clamped at 4.44 V.
// - frequency trim 00 nominal, 01 plus ten percent, 10 minus ten percent.
// - charge current 500 mA plus code times 100 mA, capped at 3 A.
// - termination 50 mA plus code times 50 mA, capped at 300 mA.
// - identification register read-only: vendor code, part code, low bits unused.
// - watchdog expiry in boost clears mode bit and pulses outputs.
// - reads of unimplemented addresses return all ones.
module ccr_register_bank
    import ccr_pkg::*;
#(
    parameter int PULSE_CYCLES = PULSE_CYCLES_DEF,
    parameter int WDOG_CYCLES = WDOG_CYCLES_DEF,
    // arbitrary identification values
    parameter logic [2:0] VENDOR_CODE = 3'h5,
    parameter logic [1:0] PART_CODE = 2'h2
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // register port from the serial engine
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    // charger conditions
    input wire logic [7:0] fault_cond_i,
    input wire logic charging_i,
    input wire logic charge_done_i,
    input wire logic undervoltage_lockout_i,
    input wire logic current_select_i,
    input wire logic supplement_i,
    // event outputs
    output logic status_pulse_o,
    output logic int_pulse_o,
    // power path and charger control
    output logic boost_mode_o,
    output logic storage_latch_off_o,
    output logic converter_off_o,
    output logic battery_switch_on_o,
    output logic external_switch_gate_o,
    output logic charge_enable_o,
    output logic termination_enable_o,
    output logic [2:0] input_limit_o,
    output logic [5:0] battery_target_code_o,
    output logic [1:0] freq_trim_o,
    output logic [4:0] charge_current_code_o,
    output logic [2:0] term_current_code_o,
    output logic default_mode_o,
    output logic watchdog_running_o
);

    localparam int WW = $clog2(WDOG_CYCLES + 1);
    localparam logic [WW-1:0] WDOG_LOAD = WW'(WDOG_CYCLES);

    // host registers
    logic boost_reg;
    logic ship_reg;
    logic [7:0] ctl_reg;
    logic [7:0] volt_reg;
    logic [7:0] cur_reg;
    ccr_mode_e mode_reg;
    ccr_mode_e mode_next;
    logic [WW-1:0] wdog_reg;
    logic [WW-1:0] wdog_next;

    // status state
    logic [1:0] stat_reg;
    logic [2:0] fault_reg;
    logic [2:0] fault_next;
    logic fault_read_reg;
    logic fault_read_next;
    logic undervoltage_lockout_prev_reg;
    logic pulse_fault_reg;

    // address decode
    wire hit_status = (addr_i == ADDR_STATUS);
    wire hit_control = (addr_i == ADDR_CONTROL);
    wire hit_voltage = (addr_i == ADDR_VOLTAGE);
    wire hit_ident = (addr_i == ADDR_IDENT);
    wire hit_current = (addr_i == ADDR_CURRENT);
    wire wr_status = wr_i && hit_status;
    wire wr_control = wr_i && hit_control;
    wire soft_rst = wr_control && wdata_i[CTL_RESET_BIT];
    wire kick = wr_status && wdata_i[STS_KICK_BIT];
    wire status_read = rd_i && hit_status;

    // watchdog
    wire wdog_on = (mode_reg == MODE_HOST);
    wire wdog_expire = wdog_on && (wdog_reg == '0);
    wire boost_expire = wdog_expire && boost_reg;

    always_comb begin
        mode_next = mode_reg;
        wdog_next = wdog_reg;
        case (mode_reg)
            MODE_DEFAULT: begin
                if (kick) begin
                    mode_next = MODE_HOST;
                    wdog_next = WDOG_LOAD;
                end
            end
            MODE_HOST: begin
                if (kick) begin
                    wdog_next = WDOG_LOAD;
                end else if (wdog_expire) begin
                    mode_next = MODE_DEFAULT;
                end else begin
                    wdog_next = wdog_reg - 1'b1;
                end
            end
            default: begin
                mode_next = MODE_DEFAULT;
            end
        endcase
        if (soft_rst) begin
            mode_next = MODE_DEFAULT;
            wdog_next = '0;
        end
    end

    // fault priority, lowest code wins
    logic [FAULT_SOURCES-1:0] fault_src;
    logic [2:0] fault_now;
    assign fault_src = fault_cond_i | (FAULT_SOURCES'(wdog_expire) << FAULT_TIMER_IDX);

    wire [FAULT_SOURCES:0] fault_seen;
    wire [2:0] fault_pick [FAULT_SOURCES+1];
    assign fault_seen[0] = 1'b0;
    assign fault_pick[0] = FAULT_NONE;
    for (genvar g = 0; g < FAULT_SOURCES; g++) begin : g_fault
        assign fault_seen[g+1] = fault_seen[g] || fault_src[g];
        assign fault_pick[g+1] = (fault_src[g] && !fault_seen[g]) ? 3'(g + 1)
            : fault_pick[g];
    end
    assign fault_now = fault_pick[FAULT_SOURCES];

    wire fault_new = (fault_now != FAULT_NONE)
        && ((fault_reg == FAULT_NONE) || (fault_now < fault_reg));

    // a new fault in the read cycle still latches and needs its own read
    always_comb begin
        fault_next = fault_reg;
        fault_read_next = fault_read_reg || status_read;
        if (fault_new) begin
            fault_next = fault_now;
            fault_read_next = 1'b0;
        end else if (fault_read_reg && fault_now == FAULT_NONE) begin
            fault_next = FAULT_NONE;
            fault_read_next = 1'b0;
        end
    end

    // charge status follows the live conditions
    logic [1:0] stat_now;
    assign stat_now = (fault_now != FAULT_NONE) ? STAT_FAULT :
        charge_done_i ? STAT_DONE :
        charging_i ? STAT_CHARGING : STAT_READY;

    wire fault_event = fault_new || boost_expire;
    wire stat_event = (stat_now != stat_reg) || fault_event;

    // pulse generation
    ccr_pulse_if pulse_bus ();
    assign pulse_bus.start = stat_event;

    ccr_pulse_timer #(
        .CYCLES(PULSE_CYCLES)
    ) u_pulse (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pl(pulse_bus)
    );

    wire pulse_begin = stat_event && !pulse_bus.active;
    wire en_stat = ctl_reg[CTL_EN_STAT_BIT];
    wire stat_pulse_next = pulse_bus.active && (en_stat || pulse_fault_reg);

    // undervoltage_lockout falling edge releases the storage latch
    wire undervoltage_lockout_fall = undervoltage_lockout_prev_reg && !undervoltage_lockout_i;

    // register writes
    wire boost_next = boost_expire ? 1'b0 : (wr_status ? wdata_i[STS_BOOST_BIT] : boost_reg);
    wire ship_next = wr_status ? wdata_i[STS_SHIP_BIT] : (undervoltage_lockout_fall ? 1'b0 : ship_reg);

    logic [5:0] vcode_wr;
    assign vcode_wr = (wdata_i[7:2] > VBAT_CODE_MAX) ? VBAT_CODE_MAX : wdata_i[7:2];

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            boost_reg <= 1'b0;
            ship_reg <= 1'b0;
            ctl_reg <= CTL_RESET_VAL;
            volt_reg <= VOLT_RESET_VAL;
            cur_reg <= CUR_RESET_VAL;
        end else if (soft_rst) begin
            boost_reg <= 1'b0;
            ship_reg <= 1'b0;
            ctl_reg <= CTL_RESET_VAL;
            volt_reg <= VOLT_RESET_VAL;
            cur_reg <= CUR_RESET_VAL;
        end else begin
            boost_reg <= boost_next;
            ship_reg <= ship_next;
            if (wr_control) begin
                ctl_reg <= {1'b1, wdata_i[6:0]};
            end
            if (wr_i && hit_voltage) begin
                volt_reg <= {vcode_wr, wdata_i[1:0]};
            end
            if (wr_i && hit_current) begin
                cur_reg <= wdata_i;
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            mode_reg <= MODE_DEFAULT;
            wdog_reg <= '0;
        end else begin
            mode_reg <= mode_next;
            wdog_reg <= wdog_next;
        end
    end

    // status and fault state
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            fault_reg <= FAULT_NONE;
            fault_read_reg <= 1'b0;
            stat_reg <= STAT_READY;
            undervoltage_lockout_prev_reg <= 1'b0;
            pulse_fault_reg <= 1'b0;
        end else begin
            fault_reg <= fault_next;
            fault_read_reg <= fault_read_next;
            stat_reg <= stat_now;
            undervoltage_lockout_prev_reg <= undervoltage_lockout_i;
            if (pulse_begin) begin
                pulse_fault_reg <= fault_event;
            end
        end
    end

    // read mux
    logic [7:0] rd_status;
    logic [7:0] rd_ident;
    logic [7:0] rd_value;
    assign rd_status = {1'b0, boost_reg, stat_reg, ship_reg, fault_reg};
    assign rd_ident = {VENDOR_CODE, PART_CODE, 3'h0};
    assign rd_value = hit_status ? rd_status :
        hit_control ? {1'b1, ctl_reg[6:0]} :
        hit_voltage ? volt_reg :
        hit_ident ? rd_ident :
        hit_current ? cur_reg : UNMAPPED_READ;

    // effective controls
    wire hiz = ctl_reg[CTL_HIZ_BIT];
    wire chg_dis = ctl_reg[CTL_CHG_DIS_BIT];
    wire in_default = (mode_next == MODE_DEFAULT);
    logic [2:0] ilim_eff;
    logic [1:0] trim_eff;
    logic [4:0] ichg_eff;
    logic [2:0] iterm_eff;
    assign ilim_eff = in_default ? (current_select_i ? ILIM_PSEL_HIGH : ILIM_PSEL_LOW)
        : ctl_reg[CTL_ILIM_LSB +: 3];
    assign trim_eff = (volt_reg[1:0] == FREQ_RESERVED) ? FREQ_NOMINAL : volt_reg[1:0];
    assign ichg_eff = (cur_reg[7:3] > ICHG_CODE_MAX) ? ICHG_CODE_MAX : cur_reg[7:3];
    assign iterm_eff = (cur_reg[2:0] > ITERM_CODE_MAX) ? ITERM_CODE_MAX : cur_reg[2:0];

    // power path: storage latch dominates, then high impedance
    wire conv_off_next = ship_reg || hiz;
    wire batt_on_next = !ship_reg && (hiz || !chg_dis || supplement_i);
    wire gate_next = ship_reg || !hiz;

    // read data and event outputs, all registered
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_o <= 8'h00;
            status_pulse_o <= 1'b0;
            int_pulse_o <= 1'b0;
        end else begin
            if (rd_i) begin
                rdata_o <= rd_value;
            end
            status_pulse_o <= stat_pulse_next;
            int_pulse_o <= pulse_bus.active;
        end
    end

    // control outputs, all registered
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            boost_mode_o <= 1'b0;
            storage_latch_off_o <= 1'b0;
            converter_off_o <= 1'b0;
            battery_switch_on_o <= 1'b0;
            external_switch_gate_o <= 1'b1;
            charge_enable_o <= 1'b0;
            termination_enable_o <= 1'b0;
            input_limit_o <= 3'h0;
            battery_target_code_o <= 6'h00;
            freq_trim_o <= 2'h0;
            charge_current_code_o <= 5'h00;
            term_current_code_o <= 3'h0;
            default_mode_o <= 1'b1;
            watchdog_running_o <= 1'b0;
        end else begin
            boost_mode_o <= boost_reg;
            storage_latch_off_o <= ship_reg;
            converter_off_o <= conv_off_next;
            battery_switch_on_o <= batt_on_next;
            external_switch_gate_o <= gate_next;
            charge_enable_o <= !chg_dis && !ship_reg && !hiz;
            termination_enable_o <= ctl_reg[CTL_TERM_EN_BIT];
            input_limit_o <= ilim_eff;
            battery_target_code_o <= volt_reg[7:VOLT_CODE_LSB];
            freq_trim_o <= trim_eff;
            charge_current_code_o <= ichg_eff;
            term_current_code_o <= iterm_eff;
            default_mode_o <= in_default;
            watchdog_running_o <= (mode_next == MODE_HOST);
        end
    end

endmodule

// *** ccr_pkg.sv ***
package ccr_pkg;

    // clock and timing
    localparam int CLK_PERIOD_NS = 8;
    localparam int PULSE_TIME_NS = 128000;
    localparam int PULSE_CYCLES_DEF = (PULSE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WDOG_TIME_MS = 50;
    localparam int WDOG_CYCLES_DEF = (WDOG_TIME_MS * 1000000) / CLK_PERIOD_NS;

    // register offsets
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_CONTROL = 8'h01;
    localparam logic [7:0] ADDR_VOLTAGE = 8'h02;
    localparam logic [7:0] ADDR_IDENT = 8'h03;
    localparam logic [7:0] ADDR_CURRENT = 8'h04;
    localparam logic [7:0] UNMAPPED_READ = 8'hFF;

    // status and mode control fields
    localparam int STS_KICK_BIT = 7;
    localparam int STS_BOOST_BIT = 6;
    localparam int STS_SHIP_BIT = 3;

    // input limit and enables fields
    localparam int CTL_RESET_BIT = 7;
    localparam int CTL_ILIM_LSB = 4;
    localparam int CTL_EN_STAT_BIT = 3;
    localparam int CTL_TERM_EN_BIT = 2;
    localparam int CTL_CHG_DIS_BIT = 1;
    localparam int CTL_HIZ_BIT = 0;

    // voltage and current fields
    localparam int VOLT_CODE_LSB = 2;
    localparam int CUR_CHG_LSB = 3;

    // values after reset
    localparam logic [7:0] CTL_RESET_VAL = 8'h8C;
    localparam logic [7:0] VOLT_RESET_VAL = 8'h14;
    localparam logic [7:0] CUR_RESET_VAL = 8'h2A;

    // code limits
    localparam logic [5:0] VBAT_CODE_MAX = 6'h2F;
    localparam logic [4:0] ICHG_CODE_MAX = 5'h19;
    localparam logic [2:0] ITERM_CODE_MAX = 3'h5;
    localparam logic [1:0] FREQ_NOMINAL = 2'h0;
    localparam logic [1:0] FREQ_RESERVED = 2'h3;

    // input limit chosen by the select pin in default mode
    localparam logic [2:0] ILIM_PSEL_LOW = 3'h2;
    localparam logic [2:0] ILIM_PSEL_HIGH = 3'h4;

    // charge status and fault codes
    localparam logic [1:0] STAT_READY = 2'h0;
    localparam logic [1:0] STAT_CHARGING = 2'h1;
    localparam logic [1:0] STAT_DONE = 2'h2;
    localparam logic [1:0] STAT_FAULT = 2'h3;
    localparam logic [2:0] FAULT_NONE = 3'h0;
    localparam int FAULT_TIMER_IDX = 4;
    localparam int FAULT_SOURCES = 8;

    typedef enum logic [1:0] {
        MODE_DEFAULT = 2'b01,
        MODE_HOST = 2'b10
    } ccr_mode_e;

endpackage

// *** ccr_pulse_if.sv ***
interface ccr_pulse_if;
    logic start;
    logic active;
    modport timer (input start, output active);
    modport ctrl (output start, input active);
endinterface

// *** ccr_pulse_timer.sv ***
module ccr_pulse_timer
    import ccr_pkg::*;
#(
    parameter int CYCLES = PULSE_CYCLES_DEF
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // pulse request and level
    ccr_pulse_if.timer pl
);

    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LOAD = CW'(CYCLES);

    logic [CW-1:0] cnt_reg;
    logic [CW-1:0] cnt_next;
    wire idle = (cnt_reg == '0);

    // a start while busy is dropped so a running pulse is never cut short or restarted
    assign cnt_next = (idle && pl.start) ? LOAD : (idle ? cnt_reg : cnt_reg - 1'b1);
    assign pl.active = !idle;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

endmodule

// *** ccr_bank_checker.sv ***
module ccr_bank_checker
    import ccr_pkg::*;
#(
    parameter int PULSE_CYCLES = 20,
    parameter logic [2:0] VENDOR_CODE = 3'h3,
    parameter logic [1:0] PART_CODE = 2'h1
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // register port
    input wire logic [7:0] addr_i,
    input wire logic rd_i,
    input wire logic [7:0] rdata_o,
    // conditions
    input wire logic [7:0] fault_cond_i,
    input wire logic current_select_i,
    // outputs watched
    input wire logic status_pulse_o,
    input wire logic int_pulse_o,
    input wire logic storage_latch_off_o,
    input wire logic converter_off_o,
    input wire logic battery_switch_on_o,
    input wire logic external_switch_gate_o,
    input wire logic charge_enable_o,
    input wire logic [2:0] input_limit_o,
    input wire logic [4:0] charge_current_code_o,
    input wire logic [2:0] term_current_code_o,
    input wire logic default_mode_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // counts the high cycles of the current pulse
    int high_cnt;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            high_cnt <= 0;
        end else begin
            high_cnt <= int_pulse_o ? high_cnt + 1 : 0;
        end
    end

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    kick_reads_zero_a: assert property (rd_i && addr_i == ADDR_STATUS |=> !rdata_o[7])
        else $error("kick bit read back as one");
    reset_reads_one_a: assert property (rd_i && addr_i == ADDR_CONTROL |=> rdata_o[7])
        else $error("reset bit read back as zero");
    ident_fixed_a: assert property (rd_i && addr_i == ADDR_IDENT |=>
        rdata_o == {VENDOR_CODE, PART_CODE, 3'h0})
        else $error("identification read wrong");
    unmapped_ones_a: assert property (rd_i && addr_i > ADDR_CURRENT |=>
        rdata_o == UNMAPPED_READ)
        else $error("unmapped read not all ones");
    pulse_width_a: assert property ($fell(int_pulse_o) |-> high_cnt == PULSE_CYCLES)
        else $error("pulse width wrong");
    fault_pulse_a: assert property ($past(fault_cond_i) == 8'h00 && fault_cond_i != 8'h00
        && !int_pulse_o |-> ##[1:2] (int_pulse_o && status_pulse_o))
        else $error("fault gave no pulse");
    pulses_paired_a: assert property ($rose(status_pulse_o) |-> $rose(int_pulse_o))
        else $error("status pulse without interrupt pulse");
    hiz_path_a: assert property (converter_off_o && !storage_latch_off_o |->
        battery_switch_on_o && !external_switch_gate_o && !charge_enable_o)
        else $error("high impedance path wrong");
    ship_off_a: assert property (storage_latch_off_o |-> converter_off_o
        && external_switch_gate_o && !battery_switch_on_o && !charge_enable_o)
        else $error("latch off path wrong");
    code_clamp_a: assert property (charge_current_code_o <= ICHG_CODE_MAX
        && term_current_code_o <= ITERM_CODE_MAX)
        else $error("current code beyond limit");
    pin_limit_a: assert property (!$past(rst_i) && default_mode_o && $past(default_mode_o) |->
        input_limit_o == ($past(current_select_i) ? ILIM_PSEL_HIGH : ILIM_PSEL_LOW))
        else $error("default limit not from pin");
endmodule

// *** ccr_host_model.sv ***
module ccr_host_model (
    // clock
    input wire logic clk_i,
    // register port
    output logic [7:0] addr_o,
    output logic [7:0] wdata_o,
    output logic wr_o,
    output logic rd_o,
    input wire logic [7:0] rdata_i
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        addr_o = 8'h00;
        wdata_o = 8'h00;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end

    // idle lines flip so a stale value never looks valid
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        #1;
        addr_o = a;
        wdata_o = d;
        wr_o = 1'b1;
        @(posedge clk_i);
        #1;
        wr_o = 1'b0;
        addr_o = ~a;
        wdata_o = ~d;
    endtask

    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_i);
        #1;
        addr_o = a;
        rd_o = 1'b1;
        @(posedge clk_i);
        #1;
        d = rdata_i;
        rd_o = 1'b0;
        addr_o = ~a;
    endtask
endmodule

// *** tb_top.sv ***
module tb_top
    import ccr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // short counts keep the run small; arbitrary identification values
    localparam int PC = 20;
    localparam int WC = 200;
    localparam logic [2:0] VEND = 3'h3;
    localparam logic [1:0] PART = 2'h1;
    logic clk_i, rst_i, wr_i, rd_i, charging_i, charge_done_i;
    logic undervoltage_lockout_i, current_select_i, supplement_i;
    logic [7:0] addr_i, wdata_i, rdata_o, fault_cond_i, rv;
    logic status_pulse_o, int_pulse_o, boost_mode_o, storage_latch_off_o, converter_off_o;
    logic battery_switch_on_o, external_switch_gate_o, charge_enable_o, termination_enable_o;
    logic default_mode_o, watchdog_running_o;
    logic [2:0] input_limit_o, term_current_code_o;
    logic [5:0] battery_target_code_o;
    logic [1:0] freq_trim_o;
    logic [4:0] charge_current_code_o;
    int err_total, checks_done;

    ccr_register_bank #(.PULSE_CYCLES(PC), .WDOG_CYCLES(WC), .VENDOR_CODE(VEND),
        .PART_CODE(PART)) dut (.clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
        .fault_cond_i, .charging_i, .charge_done_i, .undervoltage_lockout_i, .current_select_i,
        .supplement_i, .status_pulse_o, .int_pulse_o, .boost_mode_o, .storage_latch_off_o,
        .converter_off_o, .battery_switch_on_o, .external_switch_gate_o, .charge_enable_o,
        .termination_enable_o, .input_limit_o, .battery_target_code_o, .freq_trim_o,
        .charge_current_code_o, .term_current_code_o, .default_mode_o, .watchdog_running_o);
    ccr_host_model host (.clk_i, .addr_o(addr_i), .wdata_o(wdata_i), .wr_o(wr_i), .rd_o(rd_i),
        .rdata_i(rdata_o));

    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    task automatic expect8(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        expect8({7'h0, got}, {7'h0, exp});
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        host.read_reg(a, rv);
        expect8(rv, exp);
    endtask
    // outputs are registered one cycle behind the register
    task automatic settle;
        repeat (2) @(posedge clk_i);
        #1;
    endtask
    task automatic wait_int(input logic lvl, input int lim);
        int n;
        n = 0;
        while (int_pulse_o !== lvl && n < lim) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        chk1(int_pulse_o, lvl);
    endtask
    task automatic report_and_stop;
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        #200000;
        err_total++;
        report_and_stop();
    end

    initial begin
        rst_i = 1'b1;
        fault_cond_i = 8'h00;
        charging_i = 1'b0;
        charge_done_i = 1'b0;
        undervoltage_lockout_i = 1'b0;
        current_select_i = 1'b1;
        supplement_i = 1'b0;
        err_total = 0;
        checks_done = 0;
        repeat (4) @(posedge clk_i);
        #1;
        rst_i = 1'b0;
        rd_chk(ADDR_STATUS, 8'h00);
        rd_chk(ADDR_CONTROL, 8'h8C);
        rd_chk(ADDR_VOLTAGE, 8'h14);
        rd_chk(ADDR_CURRENT, 8'h2A);
        host.write_reg(ADDR_IDENT, 8'h00);
        rd_chk(ADDR_IDENT, {VEND, PART, 3'h0});
        rd_chk(8'h05, 8'hFF);
        rd_chk(8'hFF, 8'hFF);
        expect8({5'h0, input_limit_o}, 8'h04);
        current_select_i = 1'b0;
        settle();
        expect8({5'h0, input_limit_o}, 8'h02);
        host.write_reg(ADDR_VOLTAGE, 8'hFF);
        rd_chk(ADDR_VOLTAGE, 8'hBF);
        expect8({2'h0, battery_target_code_o}, 8'h2F);
        expect8({6'h0, freq_trim_o}, 8'h00);
        for (int i = 0; i < 3; i++) begin
            host.write_reg(ADDR_VOLTAGE, {6'h05, i[1:0]});
            settle();
            expect8({6'h0, freq_trim_o}, {6'h0, i[1:0]});
        end
        host.write_reg(ADDR_CURRENT, 8'hFF);
        rd_chk(ADDR_CURRENT, 8'hFF);
        expect8({3'h0, charge_current_code_o}, 8'h19);
        expect8({5'h0, term_current_code_o}, 8'h05);
        host.write_reg(ADDR_CONTROL, 8'h61);
        host.write_reg(ADDR_STATUS, 8'h80);
        settle();
        chk1(watchdog_running_o, 1'b1);
        expect8({5'h0, input_limit_o}, 8'h06);
        chk1(external_switch_gate_o, 1'b0);
        chk1(converter_off_o, 1'b1);
        chk1(battery_switch_on_o, 1'b1);
        chk1(termination_enable_o, 1'b0);
        rd_chk(ADDR_STATUS, 8'h00);
        for (int i = 0; i < 8; i++) begin
            host.write_reg(ADDR_CONTROL, {1'b0, i[2:0], 4'h8});
            settle();
            expect8({5'h0, input_limit_o}, {5'h0, i[2:0]});
        end
        chk1(charge_enable_o, 1'b1);
        host.write_reg(ADDR_CONTROL, 8'h0E);
        settle();
        chk1(battery_switch_on_o, 1'b0);
        chk1(charge_enable_o, 1'b0);
        chk1(termination_enable_o, 1'b1);
        supplement_i = 1'b1;
        settle();
        chk1(battery_switch_on_o, 1'b1);
        supplement_i = 1'b0;
        host.write_reg(ADDR_STATUS, 8'h40);
        settle();
        chk1(boost_mode_o, 1'b1);
        for (int n = 0; n < 2 * WC && boost_mode_o === 1'b1; n++) @(posedge clk_i);
        #1;
        chk1(boost_mode_o, 1'b0);
        wait_int(1'b1, 4);
        host.read_reg(ADDR_STATUS, rv);
        expect8(rv & 8'h47, 8'h05);
        wait_int(1'b0, PC + 5);
        rd_chk(ADDR_STATUS, 8'h00);
        host.write_reg(ADDR_CONTROL, 8'h04);
        charging_i = 1'b1;
        wait_int(1'b1, 5);
        chk1(status_pulse_o, 1'b0);
        rd_chk(ADDR_STATUS, 8'h10);
        wait_int(1'b0, PC + 5);
        charging_i = 1'b0;
        charge_done_i = 1'b1;
        wait_int(1'b1, 5);
        wait_int(1'b0, PC + 5);
        rd_chk(ADDR_STATUS, 8'h20);
        fault_cond_i = 8'h14;
        wait_int(1'b1, 5);
        chk1(status_pulse_o, 1'b1);
        rd_chk(ADDR_STATUS, 8'h33);
        wait_int(1'b0, PC + 5);
        rd_chk(ADDR_STATUS, 8'h33);
        fault_cond_i = 8'h00;
        wait_int(1'b1, 5);
        wait_int(1'b0, PC + 5);
        rd_chk(ADDR_STATUS, 8'h20);
        fault_cond_i = 8'h81;
        rd_chk(ADDR_STATUS, 8'h31);
        fault_cond_i = 8'h00;
        host.write_reg(ADDR_STATUS, 8'h08);
        settle();
        chk1(storage_latch_off_o, 1'b1);
        undervoltage_lockout_i = 1'b1;
        settle();
        chk1(storage_latch_off_o, 1'b1);
        undervoltage_lockout_i = 1'b0;
        settle();
        chk1(storage_latch_off_o, 1'b0);
        host.write_reg(ADDR_STATUS, 8'h80);
        settle();
        chk1(default_mode_o, 1'b0);
        host.write_reg(ADDR_CONTROL, 8'h80);
        settle();
        chk1(default_mode_o, 1'b1);
        chk1(watchdog_running_o, 1'b0);
        rd_chk(ADDR_CONTROL, 8'h8C);
        rd_chk(ADDR_VOLTAGE, 8'h14);
        rd_chk(ADDR_CURRENT, 8'h2A);
        report_and_stop();
    end
endmodule

bind ccr_register_bank ccr_bank_checker #(.PULSE_CYCLES(PULSE_CYCLES),
    .VENDOR_CODE(VENDOR_CODE), .PART_CODE(PART_CODE)) chk (.clk_i, .rst_i, .addr_i, .rd_i,
    .rdata_o, .fault_cond_i, .current_select_i, .status_pulse_o, .int_pulse_o,
    .storage_latch_off_o, .converter_off_o, .battery_switch_on_o, .external_switch_gate_o,
    .charge_enable_o, .input_limit_o, .charge_current_code_o, .term_current_code_o,
    .default_mode_o);
